/* File: verilog/addr_map_pkg.sv */
/*
  Constants for the dynamic memory address mapper: configuration encodings,
  field widths and bit positions.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package addr_map_pkg;
  localparam int ADDR_W = 28;
  localparam int ROW_W = 13;
  localparam int COL_W = 11;
  localparam int BANK_W = 2;
  // data bus width encoding
  localparam logic BUS_32 = 1'b0;
  localparam logic BUS_16 = 1'b1;
  // row count encoding
  localparam logic [1:0] ROWS_2K = 2'h0;
  localparam logic [1:0] ROWS_4K = 2'h1;
  localparam logic [1:0] ROWS_8K = 2'h2;
  // column count encoding: 256, 512, 1024, 2048
  localparam logic [1:0] COLS_256 = 2'h0;
  localparam logic [1:0] COLS_512 = 2'h1;
  localparam logic [1:0] COLS_1K = 2'h2;
  localparam logic [1:0] COLS_2K = 2'h3;
  localparam int COL_BITS_MIN = 8;
  localparam int ROW_BITS_2K = 11;
  localparam int BYTE_BITS_32 = 2;
  localparam int BYTE_BITS_16 = 1;
  // reset configuration
  localparam logic RST_BUS = BUS_32;
  localparam logic [1:0] RST_ROWS = ROWS_2K;
  localparam logic [1:0] RST_COLS = COLS_256;
endpackage
`default_nettype wire

/* File: verilog/split_if.sv */
/*
  Interface carrying the active address split between mapper and field extractor.
  Assumes the configuration fields of addr_map_pkg.
*/
`default_nettype none
interface split_if;
  import addr_map_pkg::*;
  logic [4:0] col_bits;
  logic [3:0] row_bits;
  logic [1:0] byte_bits;
  modport source (output col_bits, row_bits, byte_bits);
  modport sink (input col_bits, row_bits, byte_bits);
endinterface
`default_nettype wire

/* File: verilog/field_extract.sv */
/*
  Combinational split of a byte address into byte offset, column, row and bank.
  Assumes field widths arrive through split_if, already decoded.
*/
`default_nettype none
module field_extract
(
  split_if.sink split,
  input wire logic [addr_map_pkg::ADDR_W-1:0] addr,
  output logic [1:0] byte_sel,
  output logic [addr_map_pkg::COL_W-1:0] column,
  output logic [addr_map_pkg::ROW_W-1:0] row,
  output logic [addr_map_pkg::BANK_W-1:0] bank_field
);
  import addr_map_pkg::*;
  wire [ADDR_W-1:0] past_byte = addr >> split.byte_bits;
  wire [ADDR_W-1:0] past_col = past_byte >> split.col_bits;
  wire [ADDR_W-1:0] past_row = past_col >> split.row_bits;
  wire [COL_W-1:0] col_mask = COL_W'((12'h001 << split.col_bits) - 12'h001);
  wire [ROW_W-1:0] row_mask = ROW_W'((14'h0001 << split.row_bits) - 14'h0001);

  assign byte_sel = addr[1:0] & ((split.byte_bits == 2'h2) ? 2'h3 : 2'h1);
  assign column = past_byte[COL_W-1:0] & col_mask;
  assign row = past_col[ROW_W-1:0] & row_mask;
  // bits above the bank are dropped so the image repeats
  assign bank_field = past_row[BANK_W-1:0];
endmodule
`default_nettype wire

/* File: verilog/sdram_address_mapper.sv */
/*
  Address decode slice of the dynamic memory controller: configured split of a
  bus byte address into byte, column, row and bank, registered toward the pins.
  The split in force is the one captured at the edge before the address is taken;
  decoded fields appear one edge after the address and hold until the next one.
  Assumes configuration inputs come from the controller's configuration register
  and addresses are synchronous to mclk.
*/
`default_nettype none
module sdram_address_mapper
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic cfg_bus16,
  input wire logic [1:0] cfg_rows,
  input wire logic [1:0] cfg_cols,
  input wire logic addr_valid,
  input wire logic [addr_map_pkg::ADDR_W-1:0] addr,
  output logic dec_valid,
  output logic [1:0] byte_sel,
  output logic halfword_byte_offset,
  output logic [addr_map_pkg::COL_W-1:0] column,
  output logic [addr_map_pkg::ROW_W-1:0] row,
  output logic bank_pin_high,
  output logic bank_pin_low
);
  import addr_map_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // configuration decode
  split_if split ();
  logic bus16_reg;
  logic [1:0] rows_reg;
  logic [1:0] cols_reg;

  // a new split applies to addresses taken from the following edge on
  always_ff @(posedge mclk) begin
    if (rst) begin
      bus16_reg <= RST_BUS;
    end else begin
      bus16_reg <= cfg_bus16;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      rows_reg <= RST_ROWS;
    end else begin
      rows_reg <= cfg_rows;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      cols_reg <= RST_COLS;
    end else begin
      cols_reg <= cfg_cols;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // row count decode
  wire rows_is_4k = (rows_reg == ROWS_4K);
  wire rows_is_8k = (rows_reg == ROWS_8K);
  // the unused row code falls back to 2K
  wire rows_is_2k = !rows_is_4k && !rows_is_8k;
  wire [3:0] row_bits_2k = 4'(ROW_BITS_2K);
  wire [3:0] row_bits_4k = 4'(ROW_BITS_2K + 1);
  wire [3:0] row_bits_8k = 4'(ROW_BITS_2K + 2);
  wire [3:0] row_bits_w = ({4{rows_is_2k}} & row_bits_2k) |
                          ({4{rows_is_4k}} & row_bits_4k) |
                          ({4{rows_is_8k}} & row_bits_8k);

  ////////////////////////////////////////////////////////////////////////////
  // column count decode: each extra column bit moves row and bank up by one
  wire cols_is_256 = (cols_reg == COLS_256);
  wire cols_is_512 = (cols_reg == COLS_512);
  wire cols_is_1k = (cols_reg == COLS_1K);
  wire cols_is_2k = (cols_reg == COLS_2K);
  wire [4:0] col_bits_256 = 5'(COL_BITS_MIN);
  wire [4:0] col_bits_512 = 5'(COL_BITS_MIN + 1);
  wire [4:0] col_bits_1k = 5'(COL_BITS_MIN + 2);
  wire [4:0] col_bits_2k = 5'(COL_BITS_MIN + 3);
  wire [4:0] col_bits_w = ({5{cols_is_256}} & col_bits_256) |
                          ({5{cols_is_512}} & col_bits_512) |
                          ({5{cols_is_1k}} & col_bits_1k) |
                          ({5{cols_is_2k}} & col_bits_2k);

  ////////////////////////////////////////////////////////////////////////////
  // data bus width decode: two byte bits on a word bus, one on a half-word bus
  wire bus_is_16 = (bus16_reg == BUS_16);
  wire [1:0] byte_bits_word = 2'(BYTE_BITS_32);
  wire [1:0] byte_bits_half = 2'(BYTE_BITS_16);
  wire [1:0] byte_bits_w = bus_is_16 ? byte_bits_half : byte_bits_word;

  assign split.row_bits = row_bits_w;
  assign split.col_bits = col_bits_w;
  assign split.byte_bits = byte_bits_w;

  ////////////////////////////////////////////////////////////////////////////
  // field extraction
  logic [1:0] byte_w;
  logic [COL_W-1:0] col_w;
  logic [ROW_W-1:0] row_w;
  logic [BANK_W-1:0] bank_w;

  field_extract u_extract (
    .split(split),
    .addr(addr),
    .byte_sel(byte_w),
    .column(col_w),
    .row(row_w),
    .bank_field(bank_w)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next values: every field except dec_valid holds until the next taken address
  logic dec_valid_next;
  logic [1:0] byte_sel_next;
  logic halfword_next;
  logic [COL_W-1:0] column_next;
  logic [ROW_W-1:0] row_next;
  logic bank_high_next;
  logic bank_low_next;

  // registered fields, copied onto the ports
  logic dec_valid_reg;
  logic [1:0] byte_sel_reg;
  logic halfword_reg;
  logic [COL_W-1:0] column_reg;
  logic [ROW_W-1:0] row_reg;
  logic bank_high_reg;
  logic bank_low_reg;

  assign dec_valid_next = addr_valid;
  assign byte_sel_next = addr_valid ? byte_w : byte_sel_reg;
  assign halfword_next = addr_valid ? byte_w[0] : halfword_reg;
  assign column_next = addr_valid ? col_w : column_reg;
  assign row_next = addr_valid ? row_w : row_reg;
  assign bank_high_next = addr_valid ? bank_w[1] : bank_high_reg;
  assign bank_low_next = addr_valid ? bank_w[0] : bank_low_reg;

  ////////////////////////////////////////////////////////////////////////////
  // output registers
  always_ff @(posedge mclk) begin
    if (rst) begin
      dec_valid_reg <= 1'b0;
    end else begin
      dec_valid_reg <= dec_valid_next;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      byte_sel_reg <= 2'h0;
    end else begin
      byte_sel_reg <= byte_sel_next;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      halfword_reg <= 1'b0;
    end else begin
      halfword_reg <= halfword_next;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      column_reg <= '0;
    end else begin
      column_reg <= column_next;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      row_reg <= '0;
    end else begin
      row_reg <= row_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bank pins: upper bank bit on the high pin, lower bit on the low pin
  always_ff @(posedge mclk) begin
    if (rst) begin
      bank_high_reg <= 1'b0;
    end else begin
      bank_high_reg <= bank_high_next;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      bank_low_reg <= 1'b0;
    end else begin
      bank_low_reg <= bank_low_next;
    end
  end

  assign dec_valid = dec_valid_reg;
  assign byte_sel = byte_sel_reg;
  assign halfword_byte_offset = halfword_reg;
  assign column = column_reg;
  assign row = row_reg;
  assign bank_pin_high = bank_high_reg;
  assign bank_pin_low = bank_low_reg;
endmodule
`default_nettype wire

/* File: verification/bus_master_model.sv */
/* bus master model: applies a split, then one address a cycle later
   assumes mclk comes from the bench */
`default_nettype none
module bus_master_model
(
  input wire logic mclk,
  output logic cfg_bus16,
  output logic [1:0] cfg_rows,
  output logic [1:0] cfg_cols,
  output logic addr_valid,
  output logic [addr_map_pkg::ADDR_W-1:0] addr
);
  import addr_map_pkg::*;
  initial {cfg_bus16, cfg_rows, cfg_cols, addr_valid, addr} = '0;
  task automatic issue(logic b, logic [1:0] r, logic [1:0] c, logic [ADDR_W-1:0] a);
    @(posedge mclk);
    {cfg_bus16, cfg_rows, cfg_cols} <= {b, r, c};
    @(posedge mclk);
    addr <= a;
    addr_valid <= 1'b1;
    @(posedge mclk);
    addr_valid <= 1'b0;
    // a released address does not keep its value
    addr <= ~a;
  endtask
endmodule
`default_nettype wire

/* File: verification/sdram_address_mapper_sva.sv */
/* checker of the address split at the mapper ports
   assumes one clock mclk and a synchronous high reset */
`default_nettype none
module sdram_address_mapper_sva
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic cfg_bus16,
  input wire logic [1:0] cfg_rows,
  input wire logic [1:0] cfg_cols,
  input wire logic addr_valid,
  input wire logic [addr_map_pkg::ADDR_W-1:0] addr,
  input wire logic dec_valid,
  input wire logic [1:0] byte_sel,
  input wire logic halfword_byte_offset,
  input wire logic [addr_map_pkg::COL_W-1:0] column,
  input wire logic [addr_map_pkg::ROW_W-1:0] row,
  input wire logic bank_pin_high,
  input wire logic bank_pin_low
);
  import addr_map_pkg::*;
  logic [4:0] cfg_q;
  logic ok;
  always_ff @(posedge mclk) cfg_q <= {cfg_bus16, cfg_rows, cfg_cols};
  // a request whose split was already settled one edge earlier
  assign ok = addr_valid && cfg_q == {cfg_bus16, cfg_rows, cfg_cols};
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  sequence s_take(logic b, logic [1:0] r, logic [1:0] c);
    ok && cfg_bus16 == b && cfg_rows == r && cfg_cols == c;
  endsequence
  chk_valid_lat: assert property (addr_valid |=> dec_valid)
    else $error("valid");
  chk_valid_drop: assert property (!addr_valid |=> !dec_valid)
    else $error("valid drop");
  chk_word_byte: assert property (ok && !cfg_bus16 |=> byte_sel == $past(addr[1:0]))
    else $error("byte");
  chk_half_byte: assert property (ok && cfg_bus16 |=> halfword_byte_offset == $past(addr[0]))
    else $error("half");
  chk_bank_pins: assert property (s_take(BUS_32, ROWS_4K, COLS_256)
    |=> {bank_pin_high, bank_pin_low} == $past(addr[23:22])) else $error("bank");
  chk_row_4k: assert property (s_take(BUS_32, ROWS_4K, COLS_256)
    |=> row == {1'b0, $past(addr[21:10])}) else $error("row4");
  chk_row_8k: assert property (s_take(BUS_32, ROWS_8K, COLS_256)
    |=> row == $past(addr[22:10]) && bank_pin_high == $past(addr[24])) else $error("row8");
  chk_col_wide: assert property (s_take(BUS_32, ROWS_8K, COLS_2K)
    |=> column == $past(addr[12:2]) && bank_pin_low == $past(addr[26])) else $error("col");
  chk_half_map: assert property (s_take(BUS_16, ROWS_2K, COLS_256)
    |=> row == {2'h0, $past(addr[19:9])} && bank_pin_low == $past(addr[20])) else $error("h2k");
endmodule
bind sdram_address_mapper sdram_address_mapper_sva i_sdram_address_mapper_sva (
  .mclk(mclk),
  .rst(rst),
  .cfg_bus16(cfg_bus16),
  .cfg_rows(cfg_rows),
  .cfg_cols(cfg_cols),
  .addr_valid(addr_valid),
  .addr(addr),
  .dec_valid(dec_valid),
  .byte_sel(byte_sel),
  .halfword_byte_offset(halfword_byte_offset),
  .column(column),
  .row(row),
  .bank_pin_high(bank_pin_high),
  .bank_pin_low(bank_pin_low)
);
`default_nettype wire

/* File: verification/sdram_address_mapper_tb.sv */
/* bench of the address mapper: every split, fields worked out from the bit layout
   assumes the bus master model drives all mapper inputs except mclk and rst, which come from the bench */
`default_nettype none
module sdram_address_mapper_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import addr_map_pkg::*;
  logic mclk = 1'b0, rst = 1'b1, cfg_bus16, addr_valid, dec_valid, byte_sel_lo, bph, bpl;
  logic [1:0] cfg_rows, cfg_cols, byte_sel;
  logic [ADDR_W-1:0] addr;
  logic [COL_W-1:0] column;
  logic [ROW_W-1:0] row;
  int n_errors = 0, compares = 0, cycles = 0;
  always #50 mclk = ~mclk;
  bus_master_model i_bus_master_model (.mclk(mclk), .cfg_bus16(cfg_bus16),
    .cfg_rows(cfg_rows), .cfg_cols(cfg_cols), .addr_valid(addr_valid), .addr(addr));
  sdram_address_mapper i_sdram_address_mapper (.mclk(mclk), .rst(rst), .cfg_bus16(cfg_bus16),
    .cfg_rows(cfg_rows), .cfg_cols(cfg_cols), .addr_valid(addr_valid), .addr(addr),
    .dec_valid(dec_valid), .byte_sel(byte_sel), .halfword_byte_offset(byte_sel_lo),
    .column(column), .row(row), .bank_pin_high(bph), .bank_pin_low(bpl));
  task automatic check(logic [12:0] seen, logic [12:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic probe(logic b, logic [1:0] r, logic [1:0] c, logic [ADDR_W-1:0] a);
    int bb, cb, rb;
    bb = b ? 1 : 2;
    cb = 8 + c;
    rb = (r == ROWS_8K) ? 13 : (r == ROWS_4K) ? 12 : 11;
    i_bus_master_model.issue(b, r, c, a);
    #1;
    check(13'(dec_valid), 13'h0001);
    check(13'(byte_sel), 13'(a & (b ? 1 : 3)));
    check(13'(byte_sel_lo), 13'(a & 1));
    check(13'(column), 13'((a >> bb) & ((1 << cb) - 1)));
    check(row, 13'((a >> (bb + cb)) & ((1 << rb) - 1)));
    check(13'({bph, bpl}), 13'((a >> (bb + cb + rb)) & 3));
    @(posedge mclk);
    #1;
    check(13'(dec_valid), 13'h0000);
    check(13'(column), 13'((a >> bb) & ((1 << cb) - 1)));
  endtask
  task automatic t_word();
    for (int r = 0; r < 4; r++)
      for (int c = 0; c < 4; c++) probe(BUS_32, 2'(r), 2'(c), 28'hFEDCBA7 ^ 28'(r * 28'h0555555));
  endtask
  task automatic t_half();
    for (int r = 0; r < 4; r++)
      for (int c = 0; c < 4; c++) probe(BUS_16, 2'(r), 2'(c), 28'hF3A5C69 ^ 28'(c));
  endtask
  task automatic report_and_stop();
    $display("n_errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 500) begin
      n_errors++;
      report_and_stop();
    end
  end
  initial begin
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    t_word();
    t_half();
    report_and_stop();
  end
endmodule
`default_nettype wire
